// File: common/atac_defs.svh
// Constants for the converter track and accumulate control block
`ifndef ATAC_DEFS_SVH
`define ATAC_DEFS_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ATAC_ACC_CFG_ADDR 8'hBA
`define ATAC_CTRL_ADDR 8'hE8
`define ATAC_MUX_ADDR 8'hBB
`define ATAC_RES_LO_ADDR 8'hBD
`define ATAC_RES_HI_ADDR 8'hBE
// ----------------------------------------
// Field positions
// ----------------------------------------
`define ATAC_TWELVE_BIT 7
`define ATAC_ACC_EN_BIT 6
`define ATAC_SJ_HI 5
`define ATAC_SJ_LO 3
`define ATAC_RPT_HI 2
`define ATAC_RPT_LO 0
`define ATAC_CTL_ENABLE_BIT 7
`define ATAC_CTL_TRACK_BIT 6
`define ATAC_CTL_DONE_BIT 5
`define ATAC_CTL_BUSY_BIT 4
`define ATAC_CTL_BURST_BIT 3
`define ATAC_CTL_EXT_BIT 2
// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define ATAC_ACC_CFG_RST 8'h00
`define ATAC_CTRL_RST 8'h00
`define ATAC_MUX_RST 5'h1F
`define ATAC_TRACK_SAR_CLKS 3
`define ATAC_CONV_CLKS_10 12
`define ATAC_CONV_CLKS_12 14
`endif

// File: common/atac_pkg.sv
// Types for the converter track and accumulate control block
package atac_pkg;
  // ----------------------------------------
  // Sequencer states, one-hot
  // ----------------------------------------
  typedef enum logic [3:0] {
    ATAC_IDLE = 4'h1,
    ATAC_TRACK = 4'h2,
    ATAC_CONV = 4'h4,
    ATAC_ACCUM = 4'h8
  } atac_state_t;
endpackage : atac_pkg

// File: rtl/atac_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module atac_sync (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic resetn_in,
  // Asynchronous level in, filtered level out
  input wire logic async_in,
  output logic level_out
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } atac_sync_st_t;
  atac_sync_st_t q_r;
  atac_sync_st_t q_nxt;

  // Level changes only when stages two and three agree
  always_comb begin
    q_nxt = q_r;
    q_nxt.s1 = async_in;
    q_nxt.s2 = q_r.s1;
    q_nxt.s3 = q_r.s2;
    if (q_r.s2 == q_r.s3) begin
      q_nxt.lvl = q_r.s3;
    end
  end

  // Idle level high so a high pin at reset is not a rising edge
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      q_r <= 4'hF;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign level_out = q_r.lvl;
endmodule : atac_sync

// File: rtl/atac_core.sv
// Converter track-and-hold sequencing, accumulation and result formatting
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ps
`include "atac_defs.svh"
module atac_core
  import atac_pkg::*;
#(
  parameter int NUM_PINS = 16
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic resetn_in,
  // Register port
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  // Conversion start sources
  input wire logic soft_start_in,
  input wire logic external_convert_start_in,
  // Power state
  input wire logic low_power_in,
  // Analog front end
  output logic track_out,
  output logic convert_out,
  output logic [4:0] analog_input_selector_out,
  input wire logic sar_valid_in,
  input wire logic [11:0] sar_data_in,
  // Completion
  output logic done_out
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    atac_state_t st;
    logic twelve_bit_enable;
    logic accumulate_enable;
    logic [2:0] shift_justify_select;
    logic [2:0] repeat_count;
    logic enable;
    logic low_power_track_select;
    logic done;
    logic burst_mode_enable;
    logic ext_start_sel;
    logic [4:0] mux;
    logic [17:0] acc;
    logic lo_zero;
    logic [6:0] left;
    logic [3:0] cnt;
    logic pin_d;
    logic [7:0] rdata;
  } atac_st_t;
  atac_st_t q_r;
  atac_st_t q_nxt;
  logic pin_lvl;

  // ----------------------------------------
  // Helper functions
  // ----------------------------------------
  // Number of conversions for a repeat code; reserved codes run once
  function automatic logic [6:0] atac_repeats(input logic [2:0] code);
    case (code)
      3'h1: atac_repeats = 7'h04;
      3'h2: atac_repeats = 7'h08;
      3'h3: atac_repeats = 7'h10;
      3'h4: atac_repeats = 7'h20;
      3'h5: atac_repeats = 7'h40;
      default: atac_repeats = 7'h01;
    endcase
  endfunction : atac_repeats

  // Formatted 16-bit result view of the accumulator
  function automatic logic [15:0] atac_format(input logic [17:0] acc,
                                              input logic [2:0] sj,
                                              input logic twelve);
    logic [17:0] sh;
    sh = 18'h00000;
    case (sj)
      3'h0: sh = acc;
      3'h1: sh = acc >> 1;
      3'h2: sh = acc >> 2;
      3'h3: sh = acc >> 3;
      3'h4: sh = twelve ? (acc << 4) : (acc << 6);
      default: sh = acc;
    endcase
    atac_format = sh[15:0];
  endfunction : atac_format

  // One sample widened to the sum; ten-bit mode drops the two lowest bits
  function automatic logic [17:0] atac_sample(input logic [11:0] data,
                                              input logic twelve);
    logic [11:0] val;
    val = twelve ? data : {2'h0, data[11:2]};
    atac_sample = {6'h00, val};
  endfunction : atac_sample

  // ----------------------------------------
  // Pin synchroniser
  // ----------------------------------------
  // Only levels that two stages agree on reach the edge detector
  atac_sync u_sync (
    .core_clk_in(core_clk_in),
    .resetn_in(resetn_in),
    .async_in(external_convert_start_in),
    .level_out(pin_lvl)
  );

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    logic start;
    logic pin_rise;
    logic [15:0] fmt;
    logic [3:0] conv_len;
    start = 1'b0;
    pin_rise = 1'b0;
    fmt = 16'h0000;
    conv_len = 4'h0;
    // Every field but pin_d holds by default; read data fall back to zero
    q_nxt = q_r;
    q_nxt.pin_d = pin_lvl;
    q_nxt.rdata = 8'h00;
    pin_rise = pin_lvl && !q_r.pin_d;
    fmt = atac_format(q_r.acc, q_r.shift_justify_select, q_r.twelve_bit_enable);
    conv_len = q_r.twelve_bit_enable ? 4'(`ATAC_CONV_CLKS_12) : 4'(`ATAC_CONV_CLKS_10);
    start = q_r.enable && (q_r.ext_start_sel ? pin_rise : soft_start_in);

    // ----------------------------------------
    // Register writes; a done set by the sequencer below beats this clear
    // ----------------------------------------
    if (reg_wr_in) begin
      if (reg_addr_in == `ATAC_ACC_CFG_ADDR) begin
        q_nxt.twelve_bit_enable = reg_wdata_in[`ATAC_TWELVE_BIT];
        q_nxt.accumulate_enable = reg_wdata_in[`ATAC_ACC_EN_BIT];
        q_nxt.shift_justify_select = reg_wdata_in[`ATAC_SJ_HI:`ATAC_SJ_LO];
        q_nxt.repeat_count = reg_wdata_in[`ATAC_RPT_HI:`ATAC_RPT_LO];
      end else if (reg_addr_in == `ATAC_CTRL_ADDR) begin
        q_nxt.enable = reg_wdata_in[`ATAC_CTL_ENABLE_BIT];
        q_nxt.low_power_track_select = reg_wdata_in[`ATAC_CTL_TRACK_BIT];
        q_nxt.done = q_r.done & reg_wdata_in[`ATAC_CTL_DONE_BIT];
        q_nxt.burst_mode_enable = reg_wdata_in[`ATAC_CTL_BURST_BIT];
        q_nxt.ext_start_sel = reg_wdata_in[`ATAC_CTL_EXT_BIT];
      end else if (reg_addr_in == `ATAC_MUX_ADDR) begin
        q_nxt.mux = reg_wdata_in[4:0];
      end else if (reg_addr_in == `ATAC_RES_LO_ADDR) begin
        // Only a zero low byte matters; the sum itself is not writable
        q_nxt.lo_zero = (reg_wdata_in == 8'h00);
      end else if (reg_addr_in == `ATAC_RES_HI_ADDR) begin
        // Zero in both bytes clears the sum; low byte must be written first
        if (reg_wdata_in == 8'h00 && q_r.lo_zero) begin
          q_nxt.acc = 18'h00000;
        end
        q_nxt.lo_zero = 1'b0;
      end
    end

    // ----------------------------------------
    // Register reads, data in the following cycle
    // ----------------------------------------
    if (reg_rd_in) begin
      if (reg_addr_in == `ATAC_ACC_CFG_ADDR) begin
        q_nxt.rdata = {q_r.twelve_bit_enable, 1'b0, q_r.shift_justify_select,
                       q_r.repeat_count};
      end else if (reg_addr_in == `ATAC_CTRL_ADDR) begin
        // Busy is high from the start until the accumulate cycle ends
        q_nxt.rdata = {q_r.enable, q_r.low_power_track_select, q_r.done,
                       (q_r.st != ATAC_IDLE), q_r.burst_mode_enable,
                       q_r.ext_start_sel, 2'h0};
      end else if (reg_addr_in == `ATAC_MUX_ADDR) begin
        q_nxt.rdata = {3'h0, q_r.mux};
      end else if (reg_addr_in == `ATAC_RES_LO_ADDR) begin
        q_nxt.rdata = fmt[7:0];
      end else if (reg_addr_in == `ATAC_RES_HI_ADDR) begin
        q_nxt.rdata = fmt[15:8];
      end else begin
        q_nxt.rdata = 8'h00;
      end
    end

    // ----------------------------------------
    // Conversion sequencer
    // ----------------------------------------
    case (q_r.st)
      ATAC_IDLE: begin
        // Starts in standby are dropped, not queued, so tracking stays off
        if (start && !low_power_in) begin
          q_nxt.left = q_r.burst_mode_enable ? atac_repeats(q_r.repeat_count) : 7'h01;
          q_nxt.cnt = 4'h0;
          // Pin start already tracked while low; else low-power needs fixed tracking
          if (q_r.low_power_track_select && !q_r.ext_start_sel) begin
            q_nxt.st = ATAC_TRACK;
          end else if (q_r.burst_mode_enable) begin
            q_nxt.st = ATAC_TRACK;
          end else begin
            q_nxt.st = ATAC_CONV;
          end
          // Fresh sum per burst, or per sample when not accumulating
          if (q_r.burst_mode_enable || !q_r.accumulate_enable) begin
            q_nxt.acc = 18'h00000;
          end
        end
      end
      ATAC_TRACK: begin
        // Fixed tracking window counted from entry into the track state
        if (q_r.cnt == 4'(`ATAC_TRACK_SAR_CLKS - 1)) begin
          q_nxt.cnt = 4'h0;
          q_nxt.st = ATAC_CONV;
        end else begin
          q_nxt.cnt = q_r.cnt + 4'h1;
        end
      end
      ATAC_CONV: begin
        // SAR engine answer, or a timeout of one conversion length
        if (sar_valid_in || q_r.cnt == conv_len - 4'h1) begin
          q_nxt.cnt = 4'h0;
          q_nxt.st = ATAC_ACCUM;
        end else begin
          q_nxt.cnt = q_r.cnt + 4'h1;
        end
      end
      ATAC_ACCUM: begin
        // Sixty-four full-scale samples still fit the 18-bit sum
        q_nxt.acc = q_r.acc + atac_sample(sar_data_in, q_r.twelve_bit_enable);
        q_nxt.left = q_r.left - 7'h01;
        // Done rises only after the last repeat has been added
        if (q_r.left == 7'h01) begin
          q_nxt.done = 1'b1;
          q_nxt.st = ATAC_IDLE;
        end else begin
          q_nxt.st = ATAC_TRACK;
        end
      end
      default: q_nxt.st = ATAC_IDLE;
    endcase
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  // Reset loads constants only; pin history idles high like the pin
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      q_r.st <= ATAC_IDLE;
      {q_r.twelve_bit_enable, q_r.accumulate_enable, q_r.shift_justify_select,
       q_r.repeat_count} <= `ATAC_ACC_CFG_RST;
      {q_r.enable, q_r.low_power_track_select, q_r.done, q_r.burst_mode_enable,
       q_r.ext_start_sel} <= 5'h00;
      q_r.mux <= `ATAC_MUX_RST;
      q_r.acc <= 18'h00000;
      q_r.lo_zero <= 1'b0;
      q_r.left <= 7'h00;
      q_r.cnt <= 4'h0;
      q_r.pin_d <= 1'b1;
      q_r.rdata <= 8'h00;
    end else begin
      q_r <= q_nxt;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Tracking depends on mode; standby forces it off
  always_comb begin
    track_out = 1'b0;
    if (!q_r.enable || low_power_in) begin
      track_out = 1'b0;
    end else if (q_r.st == ATAC_TRACK) begin
      track_out = 1'b1;
    end else if (q_r.st == ATAC_IDLE || q_r.st == ATAC_ACCUM) begin
      // The sample is already taken once the accumulate cycle starts
      if (q_r.low_power_track_select) begin
        track_out = q_r.ext_start_sel && !pin_lvl;
      end else begin
        track_out = !q_r.burst_mode_enable;
      end
    end
  end

  // Conversion flag decoded by comparing the whole one-hot state register with ATAC_CONV
  assign convert_out = (q_r.st == ATAC_CONV);
  assign analog_input_selector_out = q_r.mux;
  assign done_out = q_r.done;
  assign reg_rdata_out = q_r.rdata;
endmodule : atac_core

// File: sim/atac_sar_model.sv
// Behavioural SAR engine on the far side of the control block
`timescale 1ns/1ps
module atac_sar_model (
  // Clock
  input wire logic core_clk_in,
  // Bench stimulus
  input wire logic prompt_in,
  input wire logic [11:0] sample_in,
  // Control block side
  input wire logic convert_in,
  output logic sar_valid_out,
  output logic [11:0] sar_data_out
);
  // ----
  // Conversion timing
  // ----
  int cnt_r = 0;
  logic conv_q_r = 1'b0;
  // Cycles into the conversion, and the cycle after it
  always_ff @(posedge core_clk_in) begin
    cnt_r <= convert_in ? cnt_r + 1 : 0;
    conv_q_r <= convert_in;
  end
  // Prompt engine answers in its sixth cycle; slow one lets the block time out
  assign sar_valid_out = prompt_in && convert_in && cnt_r == 5;
  // Outside the hold window the data are not worth trusting
  // Sample stands for a selected pin already set up as an analog input
  assign sar_data_out = (convert_in || conv_q_r) ? sample_in : ~sample_in;
endmodule : atac_sar_model

// File: sim/atac_chk.sv
// Port checker for the converter control block
`timescale 1ns/1ps
`include "atac_defs.svh"
module atac_chk #(
  parameter int NUM_PINS = 16
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic resetn_in,
  // Register port
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  // Starts, power, front end
  input wire logic soft_start_in,
  input wire logic external_convert_start_in,
  input wire logic low_power_in,
  input wire logic track_out,
  input wire logic convert_out,
  input wire logic [4:0] analog_input_selector_out,
  input wire logic sar_valid_in,
  input wire logic [11:0] sar_data_in,
  input wire logic done_out
);
  // ----
  // Checks
  // ----
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!resetn_in);
  rd_quiet_a: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 8'h00)
    else $error("read data outside its cycle");
  unmapped_rd_a: assert property (reg_rd_in && reg_addr_in == 8'h00 |=> reg_rdata_out == 8'h00)
    else $error("unmapped read not zero");
  acc_wo_a: assert property (reg_rd_in && reg_addr_in == `ATAC_ACC_CFG_ADDR
    |=> !reg_rdata_out[6]) else $error("accumulate bit read back");
  mux_write_a: assert property (reg_wr_in && reg_addr_in == `ATAC_MUX_ADDR
    |=> {3'h0, analog_input_selector_out} == ($past(reg_wdata_in) & 8'h1F))
    else $error("selector");
  conv_len_a: assert property ($rose(convert_out) |-> ##[1:14] !convert_out)
    else $error("conversion too long");
  track_hold_a: assert property (convert_out |-> !track_out)
    else $error("tracking during conversion");
  standby_a: assert property (low_power_in |-> !track_out)
    else $error("tracking in standby");
  track_before_a: assert property ($rose(convert_out)
    |-> $past(track_out, 2) && $past(track_out, 3)) else $error("short tracking");
  conv_next_a: assert property ($fell(convert_out)
    |-> ##[1:5] (done_out || convert_out)) else $error("no done after conversion");
  cover property ($rose(done_out));
  cover property (sar_valid_in && convert_out);
  cover property (low_power_in && soft_start_in);
endmodule : atac_chk

// File: sim/tb.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
`include "atac_defs.svh"
module tb;
  logic core_clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [7:0] reg_addr_in = 8'h00;
  logic [7:0] reg_wdata_in = 8'h00;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic soft_start_in = 1'b0;
  logic external_convert_start_in = 1'b1;
  logic low_power_in = 1'b0;
  logic prompt = 1'b0;
  logic [11:0] sample = 12'h000;
  logic [7:0] reg_rdata_out;
  logic track_out, convert_out, done_out, sar_valid_in;
  logic [4:0] analog_input_selector_out;
  logic [11:0] sar_data_in;
  logic [31:0] seed = 32'h0B6A;
  logic [7:0] ctl, rv;
  int fails = 0;
  int compares = 0;
  int cycles = 0;
  int acc = 0;
  // ----
  // Design, far side, clock and watchdog
  // ----
  atac_core i_atac_core (.core_clk_in, .resetn_in, .reg_addr_in, .reg_wdata_in,
    .reg_wr_in, .reg_rd_in, .reg_rdata_out, .soft_start_in, .external_convert_start_in,
    .low_power_in, .track_out, .convert_out, .analog_input_selector_out, .sar_valid_in,
    .sar_data_in, .done_out);
  atac_sar_model i_atac_sar_model (.core_clk_in, .prompt_in(prompt), .sample_in(sample),
    .convert_in(convert_out), .sar_valid_out(sar_valid_in), .sar_data_out(sar_data_in));
  initial begin
    forever #5 core_clk_in = ~core_clk_in;
  end
  // Expected run is a few thousand cycles
  always @(posedge core_clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      conclude();
    end
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic conclude();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : conclude
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge core_clk_in);
    reg_wr_in <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge core_clk_in);
    reg_rd_in <= 1'b0;
    @(negedge core_clk_in);
    d = reg_rdata_out;
  endtask : rd
  // One start (soft or pin), then wait for done and clear it
  task automatic conv(input bit add, input int n, input bit tw, input bit pin);
    int v;
    seed = lfsr(seed);
    sample <= seed[11:0];
    prompt <= seed[12];
    v = tw ? seed[11:0] : seed[11:2];
    acc = add ? acc + n * v : n * v;
    repeat (4) @(posedge core_clk_in);
    external_convert_start_in <= ~pin;
    soft_start_in <= ~pin;
    repeat (pin ? 12 : 1) @(posedge core_clk_in);
    external_convert_start_in <= 1'b1;
    soft_start_in <= 1'b0;
    for (int k = 0; k < 2000 && done_out !== 1'b1; k++) @(negedge core_clk_in);
    chk(16'(done_out), 16'h0001);
    rd(`ATAC_CTRL_ADDR, rv);
    chk(16'(rv), 16'(ctl | 8'h20));
    wr(`ATAC_CTRL_ADDR, ctl);
    rd(`ATAC_CTRL_ADDR, rv);
    chk(16'(rv), 16'(ctl));
  endtask : conv
  // Result read low then high, compared with the formatted model sum
  task automatic res(input int sj, input bit tw);
    logic [7:0] lo, hi;
    int v;
    v = (sj < 4) ? acc >> sj : acc << (tw ? 4 : 6);
    rd(`ATAC_RES_LO_ADDR, lo);
    rd(`ATAC_RES_HI_ADDR, hi);
    chk({hi, lo}, v[15:0]);
  endtask : res
  // ----
  // Main sequence
  // ----
  initial begin
    repeat (16) @(posedge core_clk_in);
    resetn_in <= 1'b1;
    rd(`ATAC_ACC_CFG_ADDR, rv);
    chk(16'(rv), 16'h0000);
    rd(8'h00, rv);
    chk(16'(rv), 16'h0000);
    chk(16'(analog_input_selector_out), 16'h001F);
    wr(`ATAC_ACC_CFG_ADDR, 8'hE0);
    rd(`ATAC_ACC_CFG_ADDR, rv);
    chk(16'(rv), 16'h00A0);
    for (int i = 0; i < 32; i++) begin
      wr(`ATAC_MUX_ADDR, 8'(i));
      @(negedge core_clk_in);
      chk(16'(analog_input_selector_out), 16'(i));
    end
    $display("registers done");
    ctl = 8'h80;
    wr(`ATAC_CTRL_ADDR, ctl);
    for (int s = 0; s < 10; s++) begin
      wr(`ATAC_ACC_CFG_ADDR, {s[0], 1'b0, s[3:1], 3'b000});
      conv(0, 1, s[0], 0);
      res(s / 2, s[0]);
    end
    wr(`ATAC_ACC_CFG_ADDR, 8'h40);
    wr(`ATAC_RES_LO_ADDR, 8'h00);
    wr(`ATAC_RES_HI_ADDR, 8'h00);
    acc = 0;
    repeat (3) conv(1, 1, 0, 0);
    res(0, 0);
    $display("single and accumulate done");
    ctl = 8'h88;
    wr(`ATAC_CTRL_ADDR, ctl);
    for (int r = 0; r < 6; r++) begin
      wr(`ATAC_ACC_CFG_ADDR, 8'(r));
      wr(`ATAC_RES_LO_ADDR, 8'h00);
      wr(`ATAC_RES_HI_ADDR, 8'h00);
      conv(0, (r == 0) ? 1 : (2 << r), 0, 0);
      res(0, 0);
    end
    wr(`ATAC_ACC_CFG_ADDR, 8'h00);
    $display("burst done");
    ctl = 8'hC0;
    wr(`ATAC_CTRL_ADDR, ctl);
    conv(0, 1, 0, 0);
    res(0, 0);
    ctl = 8'hC4;
    wr(`ATAC_CTRL_ADDR, ctl);
    conv(0, 1, 0, 1);
    res(0, 0);
    $display("low power tracking done");
    ctl = 8'h80;
    wr(`ATAC_CTRL_ADDR, ctl);
    low_power_in <= 1'b1;
    @(posedge core_clk_in);
    soft_start_in <= 1'b1;
    @(posedge core_clk_in);
    soft_start_in <= 1'b0;
    repeat (30) @(negedge core_clk_in);
    chk(16'(track_out), 16'h0000);
    chk(16'(done_out), 16'h0000);
    @(posedge core_clk_in);
    low_power_in <= 1'b0;
    repeat (3) @(negedge core_clk_in);
    chk(16'(track_out), 16'h0001);
    $display("standby done");
    conclude();
  end
endmodule : tb
bind atac_core atac_chk #(.NUM_PINS(NUM_PINS)) i_atac_chk (.core_clk_in(core_clk_in),
  .resetn_in(resetn_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
  .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
  .soft_start_in(soft_start_in), .external_convert_start_in(external_convert_start_in),
  .low_power_in(low_power_in), .track_out(track_out), .convert_out(convert_out),
  .analog_input_selector_out(analog_input_selector_out), .sar_valid_in(sar_valid_in),
  .sar_data_in(sar_data_in), .done_out(done_out));
